// *** hw/lou_regs.svh ***
// register offsets, field positions and reset values of the logic operation unit
`ifndef LOU_REGS_SVH
`define LOU_REGS_SVH

// ---------------------------------------------------------------
// byte offsets on the register bus
// ---------------------------------------------------------------
`define LOU_ADR_CMD      8'h00
`define LOU_ADR_ACC      8'h04
`define LOU_ADR_FLAG     8'h08
`define LOU_ADR_IO       8'h0c
`define LOU_ADR_STAT     8'h10
`define LOU_MEM_WIN      2'h1

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define LOU_FLAG_Z       0
`define LOU_FLAG_C       1
`define LOU_FLAG_HB      2
`define LOU_FLAG_SW      3
`define LOU_CMD_ADR_LSB  8
`define LOU_CMD_IMM_LSB  16
`define LOU_STAT_BUSY    0
`define LOU_STAT_RES_LSB 8

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define LOU_RST_ACC      8'h00
`define LOU_RST_FLAG     4'h0
`define LOU_RST_IO       8'h00
`define LOU_RST_MEM      8'h00

`endif

// *** hw/lou_pkg.sv ***
// types shared by the logic operation unit
package lou_pkg;

    // operation codes, in command field order
    typedef enum logic [3:0] {
        OP_AND_AI, OP_AND_AM, OP_AND_MA,
        OP_OR_AI,  OP_OR_AM,  OP_OR_MA,
        OP_XOR_AI, OP_XOR_IA, OP_XOR_AM, OP_XOR_MA,
        OP_NOT_A,  OP_NOT_M,  OP_NEG_A,  OP_NEG_M,
        OP_NOP
    } lou_op_t;

    // where a result goes
    typedef enum logic [1:0] {
        DST_NONE, DST_ACC, DST_MEM, DST_IO
    } lou_dst_t;

    typedef enum logic {
        ST_IDLE, ST_EXEC
    } lou_state_t;

endpackage : lou_pkg

// *** hw/lou_alu.sv ***
// combinational logic datapath: result, destination and zero-flag update
`timescale 1ns/100ps
`default_nettype none

module lou_alu (
    // operation
    input  wire lou_pkg::lou_op_t  op_i,
    // operands
    input  wire logic [7:0]        acc_i,
    input  wire logic [7:0]        imm_i,
    input  wire logic [7:0]        mem_i,
    input  wire logic [7:0]        io_i,
    // result
    output logic [7:0]             res_o,
    output lou_pkg::lou_dst_t      dst_o,
    output logic                   zupd_o
);
    import lou_pkg::*;

    always_comb begin
        res_o  = acc_i;
        dst_o  = DST_NONE;
        zupd_o = 1'b1;
        case (op_i)
            OP_AND_AI: begin res_o = acc_i & imm_i; dst_o = DST_ACC; end // see [RULE_01]
            OP_AND_AM: begin res_o = acc_i & mem_i; dst_o = DST_ACC; end // see [RULE_02]
            OP_AND_MA: begin res_o = acc_i & mem_i; dst_o = DST_MEM; end // see [RULE_03]
            OP_OR_AI:  begin res_o = acc_i | imm_i; dst_o = DST_ACC; end // see [RULE_04]
            OP_OR_AM:  begin res_o = acc_i | mem_i; dst_o = DST_ACC; end // see [RULE_05]
            OP_OR_MA:  begin res_o = acc_i | mem_i; dst_o = DST_MEM; end // see [RULE_06]
            OP_XOR_AI: begin res_o = acc_i ^ imm_i; dst_o = DST_ACC; end // see [RULE_07]
            OP_XOR_IA: begin
                // io target leaves every flag alone
                res_o  = acc_i ^ io_i; // see [RULE_08]
                dst_o  = DST_IO;
                zupd_o = 1'b0;
            end
            OP_XOR_AM: begin res_o = acc_i ^ mem_i; dst_o = DST_ACC; end // see [RULE_09]
            OP_XOR_MA: begin res_o = acc_i ^ mem_i; dst_o = DST_MEM; end // see [RULE_10]
            OP_NOT_A:  begin res_o = ~acc_i; dst_o = DST_ACC; end // see [RULE_11]
            OP_NOT_M:  begin res_o = ~mem_i; dst_o = DST_MEM; end // see [RULE_12]
            OP_NEG_A:  begin res_o = 8'(~acc_i + 8'h01); dst_o = DST_ACC; end // see [RULE_13]
            OP_NEG_M:  begin res_o = 8'(~mem_i + 8'h01); dst_o = DST_MEM; end // see [RULE_14]
            default:   begin res_o = acc_i; dst_o = DST_NONE; zupd_o = 1'b0; end
        endcase
    end

endmodule // lou_alu

`default_nettype wire

// *** hw/lou_top.sv ***
// logic operation unit with its accumulator, flags, io latch and data memory
`timescale 1ns/100ps
`default_nettype none
`include "lou_regs.svh"

// Operation
// [RULE_01] and immediate into accumulator, zero flag only
// [RULE_02] and memory into accumulator, zero flag only
// [RULE_03] and into memory byte, accumulator kept
// [RULE_04] or immediate into accumulator, zero flag only
// [RULE_05] or memory into accumulator, zero flag only
// [RULE_06] or into memory byte, zero flag only
// [RULE_07] xor immediate into accumulator, zero flag only
// [RULE_08] xor into io latch, no flag changes
// [RULE_09] xor memory into accumulator, zero flag only
// [RULE_10] xor into memory byte, zero flag only
// [RULE_11] invert accumulator, zero flag only
// [RULE_12] invert memory byte, accumulator kept
// [RULE_13] negate accumulator, zero flag only
// [RULE_14] negate memory byte, zero flag only
// [RULE_15] eight-bit data; zero set when result zero
module lou_top #(
    parameter int MEM_AW = 4
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // core state
    output logic      [7:0]  acc_o,
    output logic      [3:0]  flags_o,
    output logic      [7:0]  first_port_output_latch_o,
    output logic             busy_o
);
    import lou_pkg::*;

    localparam int MEM_DEPTH = 1 << MEM_AW;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    lou_state_t        state_r, state_nxt;
    lou_op_t           op_r, op_nxt;
    logic [MEM_AW-1:0] addr_r, addr_nxt;
    logic [7:0]        imm_r, imm_nxt;
    logic [7:0]        acc_r, acc_nxt;
    logic [3:0]        flags_r, flags_nxt;
    logic [7:0]        io_r, io_nxt;
    logic [7:0]        res_r, res_nxt;
    logic [7:0]        mem_r   [MEM_DEPTH];
    logic [7:0]        mem_nxt [MEM_DEPTH];
    logic              ack_r, ack_nxt;
    logic [31:0]       dat_r, dat_nxt;

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    logic              req;
    logic              wr;
    logic              mem_hit;
    logic [MEM_AW-1:0] mem_idx;
    logic [7:0]        mem_rd;
    logic              exec;

    assign req     = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wr      = req & wb_we_i & wb_sel_i[0];
    assign mem_hit = (wb_adr_i[7:6] == `LOU_MEM_WIN) && (32'(wb_adr_i[5:2]) < MEM_DEPTH);
    assign mem_idx = MEM_AW'(wb_adr_i[5:2]);
    assign mem_rd  = mem_r[addr_r];
    assign exec    = (state_r == ST_EXEC);

    // ---------------------------------------------------------------
    // datapath
    // ---------------------------------------------------------------
    logic [7:0] alu_res;
    lou_dst_t   alu_dst;
    logic       alu_zupd;

    lou_alu u_alu (
        .op_i   (op_r),
        .acc_i  (acc_r),
        .imm_i  (imm_r),
        .mem_i  (mem_rd),
        .io_i   (io_r),
        .res_o  (alu_res),
        .dst_o  (alu_dst),
        .zupd_o (alu_zupd)
    );

    // ---------------------------------------------------------------
    // sequencer and command latch
    // ---------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        op_nxt    = op_r;
        addr_nxt  = addr_r;
        imm_nxt   = imm_r;
        case (state_r)
            ST_IDLE: begin
                // a command write starts one operation
                if (wr && !mem_hit && wb_adr_i == `LOU_ADR_CMD) begin
                    op_nxt    = lou_op_t'(wb_dat_i[3:0]);
                    state_nxt = ST_EXEC;
                    if (wb_sel_i[1]) begin
                        addr_nxt = wb_dat_i[`LOU_CMD_ADR_LSB +: MEM_AW];
                    end
                    if (wb_sel_i[2]) begin
                        imm_nxt = wb_dat_i[`LOU_CMD_IMM_LSB +: 8];
                    end
                end
            end
            ST_EXEC: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            op_r    <= OP_NOP;
            addr_r  <= '0;
            imm_r   <= 8'h00;
        end else begin
            state_r <= state_nxt;
            op_r    <= op_nxt;
            addr_r  <= addr_nxt;
            imm_r   <= imm_nxt;
        end
    end

    // ---------------------------------------------------------------
    // architectural state: execution or bus write
    // ---------------------------------------------------------------
    always_comb begin
        acc_nxt   = acc_r;
        flags_nxt = flags_r;
        io_nxt    = io_r;
        res_nxt   = res_r;
        for (int i = 0; i < MEM_DEPTH; i++) begin
            mem_nxt[i] = mem_r[i];
        end
        if (exec) begin
            res_nxt = alu_res;
            case (alu_dst)
                DST_ACC: acc_nxt = alu_res;            // see [RULE_01]
                DST_MEM: mem_nxt[addr_r] = alu_res;    // see [RULE_03]
                DST_IO:  io_nxt = alu_res;             // see [RULE_08]
                default: acc_nxt = acc_r;
            endcase
            // only zero moves; carry, half borrow and signed wrap hold
            if (alu_zupd) begin
                flags_nxt[`LOU_FLAG_Z] = (alu_res == 8'h00); // see [RULE_15]
            end
        end else if (wr) begin
            // bus writes are refused while an operation executes
            if (mem_hit) begin
                mem_nxt[mem_idx] = wb_dat_i[7:0];
            end else begin
                case (wb_adr_i)
                    `LOU_ADR_ACC:  acc_nxt   = wb_dat_i[7:0];
                    `LOU_ADR_FLAG: flags_nxt = wb_dat_i[3:0];
                    `LOU_ADR_IO:   io_nxt    = wb_dat_i[7:0];
                    default:       acc_nxt   = acc_r;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_r   <= `LOU_RST_ACC;
            flags_r <= `LOU_RST_FLAG;
            io_r    <= `LOU_RST_IO;
            res_r   <= 8'h00;
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem_r[i] <= `LOU_RST_MEM;
            end
        end else begin
            acc_r   <= acc_nxt;
            flags_r <= flags_nxt;
            io_r    <= io_nxt;
            res_r   <= res_nxt;
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem_r[i] <= mem_nxt[i];
            end
        end
    end

    // ---------------------------------------------------------------
    // bus answer
    // ---------------------------------------------------------------
    always_comb begin
        ack_nxt = req;
        dat_nxt = 32'h0000_0000;
        if (req && !wb_we_i) begin
            if (mem_hit) begin
                dat_nxt[7:0] = mem_r[mem_idx];
            end else begin
                case (wb_adr_i)
                    `LOU_ADR_CMD:  dat_nxt = {8'h00, imm_r, 4'h0, 4'(addr_r), 4'h0, op_r};
                    `LOU_ADR_ACC:  dat_nxt[7:0] = acc_r;
                    `LOU_ADR_FLAG: dat_nxt[3:0] = flags_r;
                    `LOU_ADR_IO:   dat_nxt[7:0] = io_r;
                    `LOU_ADR_STAT: begin
                        dat_nxt[`LOU_STAT_BUSY] = exec;
                        dat_nxt[`LOU_STAT_RES_LSB +: 8] = res_r;
                    end
                    default:       dat_nxt = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    assign wb_ack_o                  = ack_r;
    assign wb_dat_o                  = dat_r;
    assign acc_o                     = acc_r;
    assign flags_o                   = flags_r;
    assign first_port_output_latch_o = io_r;
    assign busy_o                    = exec;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    and_imm_a: assert property ( // see [RULE_01]
        exec && op_r == OP_AND_AI |=> acc_r == ($past(acc_r) & $past(imm_r))
    ) else $error("and immediate result wrong");

    and_macc_a: assert property ( // see [RULE_02]
        exec && op_r == OP_AND_AM |=> acc_r == ($past(acc_r) & $past(mem_rd))
    ) else $error("and memory to accumulator wrong");

    and_mem_a: assert property ( // see [RULE_03]
        exec && op_r == OP_AND_MA
        |=> mem_rd == ($past(acc_r) & $past(mem_rd)) && $stable(acc_r)
    ) else $error("and into memory wrong");

    or_imm_a: assert property ( // see [RULE_04]
        exec && op_r == OP_OR_AI |=> acc_r == ($past(acc_r) | $past(imm_r))
    ) else $error("or immediate result wrong");

    or_macc_a: assert property ( // see [RULE_05]
        exec && op_r == OP_OR_AM |=> acc_r == ($past(acc_r) | $past(mem_rd))
    ) else $error("or memory to accumulator wrong");

    or_mem_a: assert property ( // see [RULE_06]
        exec && op_r == OP_OR_MA
        |=> mem_rd == ($past(acc_r) | $past(mem_rd)) && $stable(acc_r)
    ) else $error("or into memory wrong");

    xor_imm_a: assert property ( // see [RULE_07]
        exec && op_r == OP_XOR_AI |=> acc_r == ($past(acc_r) ^ $past(imm_r))
    ) else $error("xor immediate result wrong");

    xor_io_a: assert property ( // see [RULE_08]
        exec && op_r == OP_XOR_IA
        |=> io_r == ($past(acc_r) ^ $past(io_r)) && $stable(flags_r) && $stable(acc_r)
    ) else $error("xor into io latch wrong");

    xor_macc_a: assert property ( // see [RULE_09]
        exec && op_r == OP_XOR_AM |=> acc_r == ($past(acc_r) ^ $past(mem_rd))
    ) else $error("xor memory to accumulator wrong");

    xor_mem_a: assert property ( // see [RULE_10]
        exec && op_r == OP_XOR_MA
        |=> mem_rd == ($past(acc_r) ^ $past(mem_rd)) && $stable(acc_r)
    ) else $error("xor into memory wrong");

    not_acc_a: assert property ( // see [RULE_11]
        exec && op_r == OP_NOT_A |=> acc_r == ~$past(acc_r)
    ) else $error("accumulator complement wrong");

    not_mem_a: assert property ( // see [RULE_12]
        exec && op_r == OP_NOT_M |=> mem_rd == ~$past(mem_rd) && $stable(acc_r)
    ) else $error("memory complement wrong");

    neg_acc_a: assert property ( // see [RULE_13]
        exec && op_r == OP_NEG_A |=> 8'(acc_r + $past(acc_r)) == 8'h00
    ) else $error("accumulator negate wrong");

    neg_mem_a: assert property ( // see [RULE_14]
        exec && op_r == OP_NEG_M |=> 8'(mem_rd + $past(mem_rd)) == 8'h00 && $stable(acc_r)
    ) else $error("memory negate wrong");

    zero_flag_a: assert property ( // see [RULE_15]
        exec && op_r != OP_XOR_IA && op_r <= OP_NEG_M
        |=> flags_r[`LOU_FLAG_Z] == (res_r == 8'h00) && $stable(flags_r[3:1])
    ) else $error("zero flag or other flags wrong");

    bus_ack_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o
    ) else $error("bus answer timing wrong");

endmodule // lou_top

`default_nettype wire

// *** verif/lou_wb_host.sv ***
// wishbone command source standing in for the core's decoder
`timescale 1ns/100ps
`default_nettype none

module lou_wb_host (
    // clock
    input  wire logic        clk_i,
    // wishbone master side
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic      [7:0]  adr_o,
    output logic      [3:0]  sel_o,
    output logic      [31:0] dat_o,
    input  wire logic [31:0] dat_i,
    input  wire logic        ack_i
);
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o  = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'h0;
        dat_o = 32'h0;
    end

    // one classic cycle, held until ack is sampled high
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                        input logic [31:0] wdat, output logic [31:0] rdat);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= we;
        adr_o <= adr;
        sel_o <= sel;
        dat_o <= wdat;
        do @(posedge clk_i); while (ack_i !== 1'b1);
        rdat = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        // released lines show the inverse, never a stale copy
        we_o  <= ~we;
        adr_o <= ~adr;
        sel_o <= ~sel;
        dat_o <= ~wdat;
        @(posedge clk_i);
    endtask
endmodule // lou_wb_host

`default_nettype wire

// *** verif/tb_top.sv ***
// self-checking bench for the logic operation unit
`timescale 1ns/100ps
`default_nettype none
`include "lou_regs.svh"

`define CHK(nm, exp, got) \
    begin \
        checks++; \
        if ((got) !== (exp)) begin \
            fail_count++; \
            $display("wrong value %s expected %h seen %h", nm, exp, got); \
        end \
    end

module tb_top;
    import lou_pkg::*;

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc, stb, we, ack, busy, busy_seen = 1'b0;
    logic [7:0]  adr, acc, io;
    logic [3:0]  sel, flags;
    logic [31:0] dat_w, dat_r;
    int          fail_count = 0;
    int          checks = 0;
    int          cycles = 0;

    always #5 clk_i = ~clk_i;

    lou_wb_host host (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
                      .dat_o(dat_w), .dat_i(dat_r), .ack_i(ack));

    lou_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
                 .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
                 .acc_o(acc), .flags_o(flags), .first_port_output_latch_o(io), .busy_o(busy));

    // busy as seen with the command's acknowledge
    always @(posedge clk_i) begin
        if (ack === 1'b1) begin
            busy_seen <= busy;
        end
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            summarize();
        end
    end

    task automatic summarize;
        if (fail_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
        logic [31:0] x;
        host.xfer(1'b1, a, s, d, x);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        host.xfer(1'b0, a, 4'hf, 32'h0, d);
    endtask

    // load state, run one command, compare accumulator, memory byte and flags
    task automatic op_case(input lou_op_t op, input logic [3:0] ma, input logic [7:0] imm, a0, m0,
                           input logic [3:0] f0, input logic [7:0] ea, em, input logic [3:0] ef);
        logic [31:0] d;
        wr(`LOU_ADR_ACC, {24'h0, a0});
        wr({`LOU_MEM_WIN, ma, 2'h0}, {24'h0, m0});
        wr(`LOU_ADR_FLAG, {28'h0, f0});
        wr(`LOU_ADR_CMD, {8'h0, imm, 4'h0, ma, 4'h0, op});
        `CHK("busy", 1'b1, busy_seen)
        `CHK("acc", ea, acc)
        `CHK("flags", ef, flags)
        rd({`LOU_MEM_WIN, ma, 2'h0}, d);
        `CHK("mem", {24'h0, em}, d)
    endtask

    task automatic t_reset;
        logic [31:0] d;
        `CHK("acc", 8'h00, acc)
        `CHK("flags", 4'h0, flags)
        `CHK("io", 8'h00, io)
        `CHK("busy", 1'b0, busy)
        rd(`LOU_ADR_STAT, d);
        `CHK("stat", 32'h0, d)
        rd({`LOU_MEM_WIN, 6'h14}, d);
        `CHK("mem", 32'h0, d)
    endtask

    task automatic t_and;
        op_case(OP_AND_AI, 4'h3, 8'h0f, 8'h5a, 8'h77, 4'he, 8'h0a, 8'h77, 4'he);
        op_case(OP_AND_AI, 4'h3, 8'hf0, 8'h0f, 8'h77, 4'he, 8'h00, 8'h77, 4'hf);
        op_case(OP_AND_AM, 4'h0, 8'hff, 8'hc3, 8'h3c, 4'h0, 8'h00, 8'h3c, 4'h1);
        op_case(OP_AND_AM, 4'h0, 8'h00, 8'hff, 8'h81, 4'h1, 8'h81, 8'h81, 4'h0);
        op_case(OP_AND_MA, 4'hf, 8'h00, 8'hf0, 8'h3c, 4'hf, 8'hf0, 8'h30, 4'he);
    endtask

    task automatic t_or;
        op_case(OP_OR_AI, 4'h1, 8'h00, 8'h00, 8'h44, 4'he, 8'h00, 8'h44, 4'hf);
        op_case(OP_OR_AI, 4'h1, 8'h80, 8'h12, 8'h44, 4'hf, 8'h92, 8'h44, 4'he);
        op_case(OP_OR_AM, 4'h2, 8'h00, 8'h01, 8'h10, 4'h6, 8'h11, 8'h10, 4'h6);
        op_case(OP_OR_MA, 4'h4, 8'hff, 8'h00, 8'h00, 4'he, 8'h00, 8'h00, 4'hf);
        op_case(OP_OR_MA, 4'h4, 8'h00, 8'h0c, 8'h21, 4'h9, 8'h0c, 8'h2d, 4'h8);
    endtask

    task automatic t_xor;
        op_case(OP_XOR_AI, 4'h5, 8'ha5, 8'ha5, 8'h01, 4'he, 8'h00, 8'h01, 4'hf);
        op_case(OP_XOR_AI, 4'h5, 8'h0f, 8'ha5, 8'h01, 4'h1, 8'haa, 8'h01, 4'h0);
        op_case(OP_XOR_AM, 4'h6, 8'h00, 8'hff, 8'h0f, 4'he, 8'hf0, 8'h0f, 4'he);
        op_case(OP_XOR_MA, 4'h7, 8'h00, 8'h3c, 8'h3c, 4'h0, 8'h3c, 8'h00, 4'h1);
    endtask

    task automatic t_io;
        wr(`LOU_ADR_IO, 32'h55);
        op_case(OP_XOR_IA, 4'h8, 8'h00, 8'hff, 8'h66, 4'h5, 8'hff, 8'h66, 4'h5);
        `CHK("io", 8'haa, io)
        op_case(OP_XOR_IA, 4'h8, 8'h00, 8'haa, 8'h66, 4'ha, 8'haa, 8'h66, 4'ha);
        `CHK("io", 8'h00, io)
    endtask

    task automatic t_unary;
        op_case(OP_NOT_A, 4'h9, 8'h00, 8'h38, 8'h02, 4'hf, 8'hc7, 8'h02, 4'he);
        op_case(OP_NOT_A, 4'h9, 8'h00, 8'hff, 8'h02, 4'he, 8'h00, 8'h02, 4'hf);
        op_case(OP_NOT_M, 4'ha, 8'h00, 8'h11, 8'h38, 4'h0, 8'h11, 8'hc7, 4'h0);
        op_case(OP_NOT_M, 4'ha, 8'h00, 8'h11, 8'hff, 4'h0, 8'h11, 8'h00, 4'h1);
        op_case(OP_NEG_A, 4'hb, 8'h00, 8'h38, 8'h03, 4'hf, 8'hc8, 8'h03, 4'he);
        op_case(OP_NEG_A, 4'hb, 8'h00, 8'h00, 8'h03, 4'he, 8'h00, 8'h03, 4'hf);
        op_case(OP_NEG_A, 4'hb, 8'h00, 8'h80, 8'h03, 4'h2, 8'h80, 8'h03, 4'h2);
        op_case(OP_NEG_M, 4'hc, 8'h00, 8'h22, 8'h01, 4'he, 8'h22, 8'hff, 4'he);
        op_case(OP_NEG_M, 4'hc, 8'h00, 8'h22, 8'h00, 4'h0, 8'h22, 8'h00, 4'h1);
    endtask

    task automatic t_bus;
        logic [31:0] d;
        op_case(OP_NOP, 4'hd, 8'h00, 8'h5a, 8'h0e, 4'h6, 8'h5a, 8'h0e, 4'h6);
        op_case(lou_op_t'(4'hf), 4'hd, 8'h00, 8'h00, 8'h0e, 4'h8, 8'h00, 8'h0e, 4'h8);
        // lane0 only: address and immediate of the last command are kept
        wr(`LOU_ADR_CMD, 32'h00ff_0e0a, 4'h1);
        `CHK("lane acc", 8'hff, acc)
        rd(`LOU_ADR_CMD, d);
        `CHK("cmd read", 32'h0000_0d0a, d)
        rd(`LOU_ADR_STAT, d);
        `CHK("stat read", 32'h0000_ff00, d)
        rd(`LOU_ADR_FLAG, d);
        `CHK("flag read", 32'h0000_0008, d)
        wr(`LOU_ADR_ACC, 32'h0000_00c3);
        wr(`LOU_ADR_ACC, 32'hffff_ff11, 4'he);
        rd(`LOU_ADR_ACC, d);
        `CHK("acc read", 32'h0000_00c3, d)
        wr(8'h20, 32'hffff_ffff);
        rd(8'h20, d);
        `CHK("unmapped", 32'h0, d)
    endtask

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_and();
        t_or();
        t_xor();
        t_io();
        t_unary();
        t_bus();
        summarize();
    end
endmodule // tb_top

`default_nettype wire
